// >>> hw/pmi_pdm_if.sv
// One PDM interface on the system clock: clock divider, phase sampling, delay lines
`timescale 1ns/10ps
`default_nettype none
module pmi_pdm_if (
	// System clock domain
	input  wire logic                        sclk,
	// Levels from the register clock domain
	input  wire logic                        rst_src,
	input  wire logic                        run_src,
	input  wire logic [1:0]                  osr_src,
	input  wire logic [pmi_pkg::MULT_W-1:0]  mult_src,
	input  wire logic [pmi_pkg::DLY_W-1:0]   dly_l_src,
	input  wire logic [pmi_pkg::DLY_W-1:0]   dly_r_src,
	// Microphone pins
	input  wire logic                        data_pin,
	output logic                             pdm_clk_ff,
	// Sample pair toward the register domain
	output logic                             pair_left_ff,
	output logic                             pair_right_ff,
	output logic                             pair_tog_ff
);
	localparam int SW = 2 + 2 + pmi_pkg::MULT_W + 2 * pmi_pkg::DLY_W + 1;
	logic [SW-1:0]                    sync1_ff;
	logic [SW-1:0]                    sync2_ff;
	logic                             srst;
	logic                             run_s;
	logic [1:0]                       osr_s;
	logic [pmi_pkg::MULT_W-1:0]       mult_s;
	logic [pmi_pkg::DLY_W-1:0]        dly_l_s;
	logic [pmi_pkg::DLY_W-1:0]        dly_r_s;
	logic                             data_s;
	logic [pmi_pkg::HALF_W-1:0]       half;
	logic                             run_eff;
	logic [pmi_pkg::HALF_W-1:0]       cnt_ff, nxt_cnt;
	logic                             nxt_pdm_clk;
	logic                             hold_ff, nxt_hold;
	logic [pmi_pkg::DLY_DEPTH-1:0]    line_l_ff, nxt_line_l;
	logic [pmi_pkg::DLY_DEPTH-1:0]    line_r_ff, nxt_line_r;
	logic                             nxt_pair_left, nxt_pair_right, nxt_pair_tog;

	// Every crossing input passes two flops; config is quasi-static
	always_ff @(posedge sclk) begin
		sync1_ff <= {rst_src, run_src, osr_src, mult_src, dly_l_src, dly_r_src, data_pin};
		sync2_ff <= sync1_ff;
	end
	assign {srst, run_s, osr_s, mult_s, dly_l_s, dly_r_s, data_s} = sync2_ff;

	// Divide scales with the system clock itself, so both families track
	// Widen before the product so the eight-times setting cannot wrap
	assign half    = {3'h0, mult_s} * {3'h0, pmi_pkg::osr_scale(osr_s)};
	assign run_eff = run_s && (half != '0);

	always_comb begin
		nxt_cnt        = cnt_ff;
		nxt_pdm_clk    = pdm_clk_ff;
		nxt_hold       = hold_ff;
		nxt_line_l     = line_l_ff;
		nxt_line_r     = line_r_ff;
		nxt_pair_left  = pair_left_ff;
		nxt_pair_right = pair_right_ff;
		nxt_pair_tog   = pair_tog_ff;
		if (!run_eff) begin
			nxt_cnt     = '0;
			nxt_pdm_clk = 1'b0;
		end else if (cnt_ff >= half - 7'h01) begin
			nxt_cnt     = '0;
			nxt_pdm_clk = !pdm_clk_ff;
			if (pdm_clk_ff) begin
				nxt_hold = data_s;
			end else begin
				// Right bit lands with its left mate, then both walk the delay lines
				nxt_line_l     = {line_l_ff[pmi_pkg::DLY_DEPTH-2:0], hold_ff};
				nxt_line_r     = {line_r_ff[pmi_pkg::DLY_DEPTH-2:0], data_s};
				nxt_pair_left  = nxt_line_l[dly_l_s];
				nxt_pair_right = nxt_line_r[dly_r_s];
				nxt_pair_tog   = !pair_tog_ff;
			end
		end else begin
			nxt_cnt = cnt_ff + 7'h01;
		end
	end

	always_ff @(posedge sclk) begin
		if (srst) begin
			cnt_ff        <= '0;
			pdm_clk_ff    <= 1'b0;
			hold_ff       <= 1'b0;
			line_l_ff     <= '0;
			line_r_ff     <= '0;
			pair_left_ff  <= 1'b0;
			pair_right_ff <= 1'b0;
			pair_tog_ff   <= 1'b0;
		end else begin
			cnt_ff        <= nxt_cnt;
			pdm_clk_ff    <= nxt_pdm_clk;
			hold_ff       <= nxt_hold;
			line_l_ff     <= nxt_line_l;
			line_r_ff     <= nxt_line_r;
			pair_left_ff  <= nxt_pair_left;
			pair_right_ff <= nxt_pair_right;
			pair_tog_ff   <= nxt_pair_tog;
		end
	end

	a_clock_stops: assert property (@(posedge sclk) disable iff (srst)
		!run_eff |=> !pdm_clk_ff) else $error("mic clock runs while interface stopped");
	a_phase_bound: assert property (@(posedge sclk) disable iff (srst)
		run_eff && $past(run_eff) && $stable(half) |-> cnt_ff < half)
		else $error("divider count beyond half period");
	a_pair_at_rise: assert property (@(posedge sclk) disable iff (srst)
		$changed(pair_tog_ff) |-> $rose(pdm_clk_ff))
		else $error("sample pair not at end of low phase");
endmodule : pmi_pdm_if
`default_nettype wire

// >>> hw/pmi_pkg.sv
// Shared constants for the PDM microphone input front end
package pmi_pkg;
	localparam int          NUM_IF        = 2;
	localparam int          NUM_CH        = 4;
	localparam logic [15:0] ADDR_ENABLE   = 16'h0300;
	localparam logic [15:0] ADDR_STATUS   = 16'h0301;
	localparam logic [15:0] ADDR_IF1_CTRL = 16'h0310;
	localparam logic [15:0] ADDR_IF2_CTRL = 16'h0318;
	localparam logic [15:0] ADDR_DLY_1R   = 16'h0316;
	localparam logic [15:0] ADDR_DLY_1L   = 16'h0312;
	localparam logic [15:0] ADDR_DLY_2R   = 16'h031e;
	localparam logic [15:0] ADDR_DLY_2L   = 16'h031a;
	localparam logic [15:0] ADDR_VOL_BASE = 16'h0320;
	localparam logic [15:0] ADDR_RAMP     = 16'h0324;
	localparam logic [15:0] ADDR_CLKCFG   = 16'h0325;
	localparam int          OSR_POS       = 13;
	localparam int          SUP_POS       = 11;
	localparam logic [1:0]  OSR_RST       = 2'h1;
	localparam logic [1:0]  SUP_RST       = 2'h0;
	localparam int          DLY_W         = 6;
	localparam int          DLY_DEPTH     = 64;
	localparam int          VOL_W         = 8;
	localparam int          LVL_W         = 9;
	localparam int          MUTE_POS      = 8;
	localparam logic [7:0]  VOL_RST       = 8'h80;
	localparam logic [7:0]  VOL_MAX       = 8'hbf;
	localparam int          RAMP_INC_POS  = 0;
	localparam int          RAMP_DEC_POS  = 4;
	localparam logic [7:0]  RAMP_RST      = 8'h00;
	localparam int          MULT_W        = 4;
	localparam int          FRAC_POS      = 4;
	localparam logic [3:0]  MULT_RST      = 4'h0;
	localparam logic [3:0]  ENABLE_RST    = 4'h0;
	localparam logic [3:0]  CHAN_UNITS    = 4'h1;
	localparam int          HALF_W        = 7;
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          RAMP_STEP_NS  = 1000;
	localparam int          RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RAMP_CNT_W    = 7;

	// Half period in system clock cycles per 12.288MHz unit of system clock
	function automatic logic [3:0] osr_scale(input logic [1:0] osr);
		case (osr)
			2'h0:    osr_scale = 4'h4;
			2'h1:    osr_scale = 4'h2;
			2'h2:    osr_scale = 4'h1;
			default: osr_scale = 4'h8;
		endcase
	endfunction : osr_scale

	function automatic logic [15:0] dly_addr(input int ch);
		case (ch)
			0:       dly_addr = ADDR_DLY_1R;
			1:       dly_addr = ADDR_DLY_1L;
			2:       dly_addr = ADDR_DLY_2R;
			default: dly_addr = ADDR_DLY_2L;
		endcase
	endfunction : dly_addr
endpackage : pmi_pkg

// >>> hw/pmi_top.sv
// PDM microphone input front end: registers, enable check, crossing, volume ramp
`timescale 1ns/10ps
`default_nettype none
module pmi_top (
	// Register clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// Register port
	input  wire logic [15:0]                 reg_addr,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	input  wire logic [15:0]                 reg_wdata,
	output logic      [15:0]                 reg_rdata,
	// System clock that feeds the microphone interfaces
	input  wire logic                        core_system_clock,
	// Microphone pins
	input  wire logic                        pdm_data_in_one,
	input  wire logic                        pdm_data_in_two,
	output logic                             pdm_clock_out_one,
	output logic                             pdm_clock_out_two,
	output logic      [1:0]                  pdm_level_reference_sel_one,
	output logic      [1:0]                  pdm_level_reference_sel_two,
	// Error toward GPIO and interrupt logic
	output logic                             underclock_err,
	// Captured channel stream
	output logic      [pmi_pkg::NUM_CH-1:0]  ch_bit,
	output logic      [pmi_pkg::NUM_IF-1:0]  ch_valid,
	output logic      [4*pmi_pkg::LVL_W-1:0] ch_gain
);
	logic [pmi_pkg::NUM_CH-1:0]              en_ff, nxt_en;
	logic [pmi_pkg::NUM_CH-1:0]              sts_ff, nxt_sts;
	logic [pmi_pkg::NUM_IF-1:0][1:0]         osr_ff, nxt_osr;
	logic [pmi_pkg::NUM_IF-1:0][1:0]         sup_ff, nxt_sup;
	logic [pmi_pkg::NUM_CH-1:0][5:0]         dly_ff, nxt_dly;
	logic [pmi_pkg::NUM_CH-1:0][7:0]         vol_ff, nxt_vol;
	logic [pmi_pkg::NUM_CH-1:0]              mute_ff, nxt_mute;
	logic [7:0]                              ramp_ff, nxt_ramp;
	logic [pmi_pkg::MULT_W-1:0]              mult_ff, nxt_mult;
	logic                                    frac_ff, nxt_frac;
	logic [15:0]                             rdata_ff, nxt_rdata;
	logic                                    err_ff, nxt_err;
	logic [pmi_pkg::NUM_CH-1:0]              req;
	logic [pmi_pkg::NUM_CH-1:0]              rise;
	logic [pmi_pkg::NUM_CH-1:0]              cand;
	logic [3:0]                              need;
	logic                                    clk_ok;
	logic [pmi_pkg::NUM_IF-1:0]              run_ff, nxt_run;
	logic [pmi_pkg::NUM_IF-1:0]              pdm_clk_w;
	logic [pmi_pkg::NUM_IF-1:0]              pair_l_w, pair_r_w, pair_tog_w;
	logic [pmi_pkg::NUM_IF-1:0]              tog1_ff, tog2_ff, tog3_ff;
	logic [pmi_pkg::NUM_IF-1:0]              pair_edge;
	logic [pmi_pkg::NUM_CH-1:0]              bit_ff, nxt_bit;
	logic [pmi_pkg::NUM_IF-1:0]              valid_ff, nxt_valid;
	logic [pmi_pkg::RAMP_CNT_W-1:0]          base_ff, nxt_base;
	logic [15:0]                             tick_ff, nxt_tick;
	logic                                    base_tick;
	logic [pmi_pkg::NUM_CH-1:0][8:0]         lvl_ff, nxt_lvl;
	logic [pmi_pkg::NUM_CH-1:0][8:0]         target;

	function automatic logic [2:0] popcount(input logic [3:0] v);
		popcount = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
	endfunction : popcount

	// Ramp step is due when the tick count is a multiple of two to the rate
	function automatic logic ramp_due(input logic [15:0] cnt, input logic [3:0] rate);
		logic [15:0] mask;
		mask     = (16'h0001 << rate) - 16'h0001;
		ramp_due = (cnt & mask) == 16'h0000;
	endfunction : ramp_due

	// Enable check against the configured system clock budget
	assign req    = reg_wdata[pmi_pkg::NUM_CH-1:0];
	assign rise   = req & ~en_ff;
	assign cand   = (sts_ff & req) | rise;
	assign need   = 4'({1'b0, popcount(cand)} * pmi_pkg::CHAN_UNITS);
	assign clk_ok = (mult_ff != '0) && (need <= mult_ff);

	always_comb begin
		nxt_en    = en_ff;
		nxt_sts   = sts_ff;
		nxt_osr   = osr_ff;
		nxt_sup   = sup_ff;
		nxt_dly   = dly_ff;
		nxt_vol   = vol_ff;
		nxt_mute  = mute_ff;
		nxt_ramp  = ramp_ff;
		nxt_mult  = mult_ff;
		nxt_frac  = frac_ff;
		nxt_err   = 1'b0;
		nxt_rdata = rdata_ff;
		if (reg_wr) begin
			case (reg_addr)
				pmi_pkg::ADDR_ENABLE: begin
					nxt_en = req;
					if ((rise != '0) && !clk_ok) begin
						// Only the new requests fail; running paths keep going
						nxt_sts = sts_ff & req;
						nxt_err = 1'b1;
					end else begin
						nxt_sts = cand;
					end
				end
				pmi_pkg::ADDR_IF1_CTRL: begin
					nxt_osr[0] = reg_wdata[pmi_pkg::OSR_POS +: 2];
					nxt_sup[0] = reg_wdata[pmi_pkg::SUP_POS +: 2];
				end
				pmi_pkg::ADDR_IF2_CTRL: begin
					nxt_osr[1] = reg_wdata[pmi_pkg::OSR_POS +: 2];
					nxt_sup[1] = reg_wdata[pmi_pkg::SUP_POS +: 2];
				end
				pmi_pkg::ADDR_RAMP: begin
					nxt_ramp = reg_wdata[7:0];
				end
				pmi_pkg::ADDR_CLKCFG: begin
					nxt_mult = reg_wdata[pmi_pkg::MULT_W-1:0];
					nxt_frac = reg_wdata[pmi_pkg::FRAC_POS];
				end
				default: begin
				end
			endcase
			for (int c = 0; c < pmi_pkg::NUM_CH; c++) begin
				if (reg_addr == pmi_pkg::dly_addr(c)) begin
					nxt_dly[c] = reg_wdata[pmi_pkg::DLY_W-1:0];
				end
				if (reg_addr == pmi_pkg::ADDR_VOL_BASE + 16'(c)) begin
					nxt_vol[c]  = reg_wdata[pmi_pkg::VOL_W-1:0];
					nxt_mute[c] = reg_wdata[pmi_pkg::MUTE_POS];
				end
			end
		end
		if (reg_rd) begin
			nxt_rdata = 16'h0000;
			case (reg_addr)
				pmi_pkg::ADDR_ENABLE:   nxt_rdata[3:0] = en_ff;
				pmi_pkg::ADDR_STATUS:   nxt_rdata[3:0] = sts_ff;
				pmi_pkg::ADDR_IF1_CTRL: begin
					nxt_rdata[pmi_pkg::OSR_POS +: 2] = osr_ff[0];
					nxt_rdata[pmi_pkg::SUP_POS +: 2] = sup_ff[0];
				end
				pmi_pkg::ADDR_IF2_CTRL: begin
					nxt_rdata[pmi_pkg::OSR_POS +: 2] = osr_ff[1];
					nxt_rdata[pmi_pkg::SUP_POS +: 2] = sup_ff[1];
				end
				pmi_pkg::ADDR_RAMP:     nxt_rdata[7:0] = ramp_ff;
				pmi_pkg::ADDR_CLKCFG:   nxt_rdata[4:0] = {frac_ff, mult_ff};
				default: begin
				end
			endcase
			for (int c = 0; c < pmi_pkg::NUM_CH; c++) begin
				if (reg_addr == pmi_pkg::dly_addr(c)) begin
					nxt_rdata[pmi_pkg::DLY_W-1:0] = dly_ff[c];
				end
				if (reg_addr == pmi_pkg::ADDR_VOL_BASE + 16'(c)) begin
					nxt_rdata[8:0] = {mute_ff[c], vol_ff[c]};
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			en_ff    <= pmi_pkg::ENABLE_RST;
			sts_ff   <= pmi_pkg::ENABLE_RST;
			osr_ff   <= {pmi_pkg::NUM_IF{pmi_pkg::OSR_RST}};
			sup_ff   <= {pmi_pkg::NUM_IF{pmi_pkg::SUP_RST}};
			dly_ff   <= '0;
			vol_ff   <= {pmi_pkg::NUM_CH{pmi_pkg::VOL_RST}};
			mute_ff  <= '1;
			ramp_ff  <= pmi_pkg::RAMP_RST;
			mult_ff  <= pmi_pkg::MULT_RST;
			frac_ff  <= 1'b0;
			err_ff   <= 1'b0;
			rdata_ff <= 16'h0000;
		end else begin
			en_ff    <= nxt_en;
			sts_ff   <= nxt_sts;
			osr_ff   <= nxt_osr;
			sup_ff   <= nxt_sup;
			dly_ff   <= nxt_dly;
			vol_ff   <= nxt_vol;
			mute_ff  <= nxt_mute;
			ramp_ff  <= nxt_ramp;
			mult_ff  <= nxt_mult;
			frac_ff  <= nxt_frac;
			err_ff   <= nxt_err;
			rdata_ff <= nxt_rdata;
		end
	end

	// Interface runs while either of its channels has its status bit set
	always_comb begin
		for (int i = 0; i < pmi_pkg::NUM_IF; i++) begin
			nxt_run[i] = sts_ff[2*i] | sts_ff[2*i+1];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			run_ff <= '0;
		end else begin
			run_ff <= nxt_run;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < pmi_pkg::NUM_IF; gi++) begin : g_if
			pmi_pdm_if u_if (
				.sclk          (core_system_clock),
				.rst_src       (rst),
				.run_src       (run_ff[gi]),
				.osr_src       (osr_ff[gi]),
				.mult_src      (mult_ff),
				.dly_l_src     (dly_ff[2*gi+1]),
				.dly_r_src     (dly_ff[2*gi]),
				.data_pin      ((gi == 0) ? pdm_data_in_one : pdm_data_in_two),
				.pdm_clk_ff    (pdm_clk_w[gi]),
				.pair_left_ff  (pair_l_w[gi]),
				.pair_right_ff (pair_r_w[gi]),
				.pair_tog_ff   (pair_tog_w[gi])
			);
		end
	endgenerate

	// Pair bits are held a whole microphone period, far past the toggle's sync delay
	always_ff @(posedge clk) begin
		tog1_ff <= pair_tog_w;
		tog2_ff <= tog1_ff;
		tog3_ff <= tog2_ff;
	end
	assign pair_edge = tog2_ff ^ tog3_ff;

	always_comb begin
		// A stopped interface sends no more pairs, so clear disabled bits here
		nxt_bit   = bit_ff & sts_ff;
		nxt_valid = '0;
		for (int i = 0; i < pmi_pkg::NUM_IF; i++) begin
			if (pair_edge[i]) begin
				nxt_bit[2*i+1] = pair_l_w[i] & sts_ff[2*i+1];
				nxt_bit[2*i]   = pair_r_w[i] & sts_ff[2*i];
				nxt_valid[i]   = run_ff[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bit_ff   <= '0;
			valid_ff <= '0;
		end else begin
			bit_ff   <= nxt_bit;
			valid_ff <= nxt_valid;
		end
	end

	// Gain level 0 is silence; code c sits at level c+1
	assign base_tick = base_ff == pmi_pkg::RAMP_CNT_W'(pmi_pkg::RAMP_STEP_CYC - 1);

	always_comb begin
		nxt_base = base_tick ? '0 : base_ff + 7'h01;
		nxt_tick = base_tick ? tick_ff + 16'h0001 : tick_ff;
		for (int c = 0; c < pmi_pkg::NUM_CH; c++) begin
			// Codes above the top step hold at the top step
			target[c] = mute_ff[c] ? 9'h000
				: {1'b0, ((vol_ff[c] > pmi_pkg::VOL_MAX) ? pmi_pkg::VOL_MAX : vol_ff[c])}
				+ 9'h001;
			nxt_lvl[c] = lvl_ff[c];
			if (base_tick && lvl_ff[c] < target[c]
				&& ramp_due(tick_ff, ramp_ff[pmi_pkg::RAMP_INC_POS +: 4])) begin
				nxt_lvl[c] = lvl_ff[c] + 9'h001;
			end else if (base_tick && lvl_ff[c] > target[c]
				&& ramp_due(tick_ff, ramp_ff[pmi_pkg::RAMP_DEC_POS +: 4])) begin
				nxt_lvl[c] = lvl_ff[c] - 9'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			base_ff <= '0;
			tick_ff <= 16'h0000;
			lvl_ff  <= '0;
		end else begin
			base_ff <= nxt_base;
			tick_ff <= nxt_tick;
			lvl_ff  <= nxt_lvl;
		end
	end

	assign reg_rdata                   = rdata_ff;
	assign pdm_clock_out_one           = pdm_clk_w[0];
	assign pdm_clock_out_two           = pdm_clk_w[1];
	assign pdm_level_reference_sel_one = sup_ff[0];
	assign pdm_level_reference_sel_two = sup_ff[1];
	assign underclock_err              = err_ff;
	assign ch_bit                      = bit_ff;
	assign ch_valid                    = valid_ff;
	assign ch_gain                     = lvl_ff;

	a_status_subset: assert property (@(posedge clk) disable iff (rst)
		(sts_ff & ~en_ff) == '0) else $error("status set without enable");
	a_reject_pulse: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == pmi_pkg::ADDR_ENABLE && rise != '0 && !clk_ok
		|=> underclock_err ##1 !underclock_err) else $error("no underclock pulse");
	a_reject_keeps: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == pmi_pkg::ADDR_ENABLE && rise != '0 && !clk_ok
		|=> sts_ff == ($past(sts_ff) & $past(req))) else $error("rejected enable changed paths");
	a_accept_sets: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == pmi_pkg::ADDR_ENABLE && clk_ok
		|=> sts_ff == (($past(sts_ff) & $past(req)) | $past(rise)) && !underclock_err)
		else $error("accepted enable not reported");
	a_status_read: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == pmi_pkg::ADDR_STATUS |=> reg_rdata == {12'h000, $past(sts_ff)})
		else $error("status readback mismatch");
	a_mute_reset: assert property (@(posedge clk)
		$past(rst) |-> mute_ff == '1 && lvl_ff == '0) else $error("path not muted after reset");
	a_ramp_step: assert property (@(posedge clk) disable iff (rst)
		!base_tick |=> $stable(lvl_ff)) else $error("gain moved off a ramp tick");
	a_gain_range: assert property (@(posedge clk) disable iff (rst)
		lvl_ff[0] <= {1'b0, pmi_pkg::VOL_MAX} + 9'h001 && lvl_ff[3] <= 9'h0c0)
		else $error("gain level out of range");
	a_bit_masked: assert property (@(posedge clk) disable iff (rst)
		$fell(sts_ff[0]) ##1 pair_edge[0] |=> !ch_bit[0]) else $error("disabled channel data");
endmodule : pmi_top
`default_nettype wire

// >>> tb/pmi_mic_pair.sv
// Pair of PDM microphones sharing one data line
`timescale 1ns/10ps
`default_nettype none
module pmi_mic_pair (
	// Clock from the device
	input  wire logic pdm_clk,
	// Bits the two microphones present
	input  wire logic left_bit,
	input  wire logic right_bit,
	// Shared data line
	output logic      data
);
	logic drv = 1'b0;

	// Handover gap: both mics released, line rests at the pin pull-down
	always @(pdm_clk) begin
		drv = 1'b0;
		#30 drv = 1'b1;
	end
	assign data = !drv ? 1'b0 : pdm_clk ? left_bit : right_bit;
endmodule : pmi_mic_pair
`default_nettype wire

// >>> tb/test_pdm_mic_input_paths.sv
// Self-checking bench for the PDM microphone input front end
`timescale 1ns/10ps
`default_nettype none
module test_pdm_mic_input_paths;
	logic        clk, rst, sclk, reg_wr, reg_rd, d1, d2, c1, c2, underclock_err;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, v, a;
	logic [1:0]  sup1, sup2, ch_valid, s;
	logic [3:0]  ch_bit, mb;
	logic [35:0] ch_gain;
	int          errors, n_tests, i, h;

	pmi_top u_pmi_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.core_system_clock(sclk), .pdm_data_in_one(d1), .pdm_data_in_two(d2),
		.pdm_clock_out_one(c1), .pdm_clock_out_two(c2), .pdm_level_reference_sel_one(sup1),
		.pdm_level_reference_sel_two(sup2), .underclock_err(underclock_err),
		.ch_bit(ch_bit), .ch_valid(ch_valid), .ch_gain(ch_gain));
	pmi_mic_pair u_pmi_mic_pair_one (.pdm_clk(c1), .left_bit(mb[1]), .right_bit(mb[0]), .data(d1));
	pmi_mic_pair u_pmi_mic_pair_two (.pdm_clk(c2), .left_bit(mb[3]), .right_bit(mb[2]), .data(d2));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Odd offset keeps the two clocks out of step
	initial begin
		sclk = 1'b0;
		#37;
		forever #80 sclk = ~sclk;
	end

	task automatic complete_run;
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic fail(input string nm);
		errors++;
		$display("[ERR] %s expected done seen timeout", nm);
		complete_run();
	endtask : fail
	task automatic wr(input logic [15:0] ad, input logic [15:0] d);
		@(posedge clk);
		#1;
		reg_addr  = ad;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] ad, input logic [15:0] e, input string nm);
		@(posedge clk);
		#1;
		reg_addr = ad;
		reg_rd   = 1'b1;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		chk(nm, e, reg_rdata);
	endtask : rd
	task automatic lvl(input logic b);
		for (int k = 0; k < 400 && c1 !== b; k++) begin
			@(posedge sclk);
			#1;
		end
		if (c1 !== b) fail("mic clock");
	endtask : lvl
	task automatic wv(input int k);
		int p;
		p = 0;
		for (int c = 0; c < 4000 && p < 8; c++) begin
			@(posedge clk);
			#1;
			if (ch_valid[k] === 1'b1) p++;
		end
		if (p < 8) fail("pair");
	endtask : wv
	task automatic gv(input logic [8:0] e);
		for (int c = 0; c < 1000 && ch_gain !== {4{e}}; c++) begin
			@(posedge clk);
			#1;
		end
		for (int c = 0; c < 4; c++) begin
			chk("gain", {7'h00, e}, {7'h00, ch_gain[9*c +: 9]});
		end
		if (ch_gain !== {4{e}}) fail("gain");
	endtask : gv
	// Interface must be stopped before its divider or delay settings move
	task automatic stop;
		wr(16'h0300, 16'h0000);
		lvl(1'b0);
		repeat (4) @(posedge sclk);
		#1;
		rd(16'h0301, 16'h0000, "status");
		chk("ch_bit", 16'h0000, {12'h000, ch_bit});
	endtask : stop
	function automatic int sc(input int o);
		return (o == 0) ? 4 : (o == 1) ? 2 : (o == 2) ? 1 : 8;
	endfunction : sc

	initial begin
		void'($urandom(89));
		{errors, n_tests} = '0;
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata, mb} = {1'b1, 38'h0};
		// Long enough for the slow domain to see reset too
		repeat (80) @(posedge clk);
		#1 rst = 1'b0;
		rd(16'h0300, 16'h0000, "enable");
		rd(16'h0301, 16'h0000, "status");
		rd(16'h0310, 16'h2000, "if1 ctrl");
		rd(16'h0320, 16'h0180, "volume");
		rd(16'h0305, 16'h0000, "unmapped");
		chk("gain", 16'h0000, {7'h00, ch_gain[8:0]});
		wr(16'h0300, 16'h0001);
		chk("err", 16'h0001, {15'h0, underclock_err});
		rd(16'h0301, 16'h0000, "status");
		wr(16'h0300, 16'h0000);
		wr(16'h0325, 16'h0002);
		wr(16'h0300, 16'h0003);
		chk("err", 16'h0000, {15'h0, underclock_err});
		wr(16'h0300, 16'h0007);
		chk("err", 16'h0001, {15'h0, underclock_err});
		wr(16'h0301, 16'h000f);
		rd(16'h0301, 16'h0003, "status");
		rd(16'h0300, 16'h0007, "enable");
		stop();
		wr(16'h0325, 16'h0001);
		for (i = 0; i < 4; i++) begin
			s = 2'($urandom_range(2, 0));
			wr(16'h0310, {1'b0, i[1:0], s, 11'h000});
			chk("sup one", {14'h0, s}, {14'h0, sup1});
			repeat (4) @(posedge sclk);
			wr(16'h0300, 16'h0001);
			half(h);
			chk("half period", 16'(sc(i)), 16'(h));
			stop();
		end
		for (i = 0; i < 4; i++) begin
			a = (i == 0) ? 16'h0316 : (i == 1) ? 16'h0312 : (i == 2) ? 16'h031e : 16'h031a;
			v = (i == 3) ? 16'h003f : 16'($urandom_range(63, 0));
			wr(a, 16'hffc0 | v);
			rd(a, v, "delay");
			wr(a, {14'h0, v[1:0]});
		end
		s = 2'($urandom_range(2, 0));
		wr(16'h0318, {3'h1, s, 11'h000});
		chk("sup two", {14'h0, s}, {14'h0, sup2});
		wr(16'h0310, 16'h2000);
		wr(16'h0325, 16'h0004);
		repeat (4) @(posedge sclk);
		wr(16'h0300, 16'h000f);
		rd(16'h0301, 16'h000f, "status");
		for (i = 0; i < 4; i++) begin
			mb = (i == 0) ? 4'ha : 4'($urandom());
			wv(0);
			wv(1);
			chk("ch_bit", {12'h000, mb}, {12'h000, ch_bit});
		end
		for (i = 0; i < 4; i++) begin
			wr(16'h0320 + 16'(i), 16'h0003);
		end
		gv(9'h004);
		for (i = 0; i < 4; i++) begin
			wr(16'h0320 + 16'(i), 16'h0103);
		end
		gv(9'h000);
		stop();
		complete_run();
	end

	task automatic half(output int n);
		lvl(1'b1);
		lvl(1'b0);
		lvl(1'b1);
		for (n = 0; n < 400 && c1 === 1'b1; n++) begin
			@(posedge sclk);
			#1;
		end
	endtask : half
endmodule : test_pdm_mic_input_paths
`default_nettype wire
